// [dv/expansion_chain_model.sv]
// Behavioural model of the chain of expansion units
`timescale 1ns/1ps
module expansion_chain_model (
  input  wire logic       clk,
  input  wire logic       attachUnknown,
  input  wire logic [3:0] attachCount,
  input  wire logic [7:0] faultUnits,
  input  wire logic [7:0] registeredUnits,
  input  wire logic [7:0] silentUnits,
  output logic            unknownUnitPin,
  output logic      [3:0] unitCountPin,
  output logic      [7:0] unitCommFaultPin,
  output logic      [7:0] unitRegisteredPin,
  output logic      [7:0] unitResponsePin
);
  logic [1:0] pace;

  initial begin
    pace            = 2'd0;
    unitResponsePin = 8'h00;
  end

  assign unknownUnitPin    = attachUnknown;
  assign unitCountPin      = attachCount;
  assign unitCommFaultPin  = faultUnits;
  assign unitRegisteredPin = registeredUnits;

  // Each live registered unit answers once every four cycles
  always @(posedge clk) begin
    pace <= pace + 2'd1;
    if (pace == 2'd0) begin
      unitResponsePin <= unitResponsePin ^ (registeredUnits & ~silentUnits);
    end
  end
endmodule : expansion_chain_model

// [dv/tb_expansion_config_error_status.sv]
// Self-checking bench for the expansion fault status register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_expansion_config_error_status;
  import fault_status_pkg::*;

  logic        clk, rst_n, wrStb, rdStb, irq;
  logic [15:0] addr, wrData, rdData, got;
  logic        attachUnknown, unknownUnitPin;
  logic [3:0]  attachCount, unitCountPin, inputCountFaultPin;
  logic [7:0]  faultUnits, registeredUnits, silentUnits;
  logic [7:0]  unitCommFaultPin, unitRegisteredPin, unitResponsePin;
  int          fails, checks, n;

  expansion_config_error_status #(.TIMEOUT_CYC(20)) DUT (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .irq(irq), .unknownUnitPin(unknownUnitPin),
    .unitCountPin(unitCountPin), .unitCommFaultPin(unitCommFaultPin),
    .unitRegisteredPin(unitRegisteredPin), .unitResponsePin(unitResponsePin),
    .inputCountFaultPin(inputCountFaultPin));

  expansion_chain_model chain (
    .clk(clk), .attachUnknown(attachUnknown), .attachCount(attachCount),
    .faultUnits(faultUnits), .registeredUnits(registeredUnits),
    .silentUnits(silentUnits), .unknownUnitPin(unknownUnitPin),
    .unitCountPin(unitCountPin), .unitCommFaultPin(unitCommFaultPin),
    .unitRegisteredPin(unitRegisteredPin), .unitResponsePin(unitResponsePin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wrStb  <= 1'b1;
    addr   <= a;
    wrData <= d;
    @(posedge clk);
    wrStb  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    rdStb <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask : rd

  task automatic expect_word(input logic [15:0] a, input logic [15:0] e);
    rd(a, got);
    `CHK(got, e)
  endtask : expect_word

  task automatic settle();
    repeat (10) @(posedge clk);
  endtask : settle

  task automatic tally_and_finish();
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    fails = 0; checks = 0;
    rst_n = 1'b0; wrStb = 1'b0; rdStb = 1'b0; addr = 16'h0000; wrData = 16'h0000;
    attachUnknown = 1'b0; attachCount = 4'h0; faultUnits = 8'h00;
    registeredUnits = 8'h00; silentUnits = 8'h00; inputCountFaultPin = 4'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    for (n = 0; n < 6; n++) expect_word(16'h0000 + 16'(n), 16'h0000);
    expect_word(16'h0007, 16'h0000);
    attachUnknown <= 1'b1;
    settle();
    expect_word(OFS_CFG_A, 16'h0001);
    expect_word(OFS_DEVICE, 16'h0002);
    attachUnknown <= 1'b0;
    settle();
    expect_word(OFS_CFG_A, 16'h0000);
    attachCount <= 4'h9;
    settle();
    expect_word(OFS_CFG_A, 16'h0000);
    attachCount <= 4'hA;
    settle();
    expect_word(OFS_CFG_A, 16'h0004);
    attachCount <= 4'h0;
    for (n = 0; n < 8; n++) begin
      faultUnits <= 8'(1 << n);
      settle();
      expect_word(OFS_CFG_B, 16'(1 << n));
      expect_word(OFS_LINK_UNIT, 16'(1 << n));
      expect_word(OFS_CFG_A, 16'h0008);
      expect_word(OFS_DEVICE, 16'h0012);
    end
    faultUnits <= 8'h00;
    for (n = 0; n < 4; n++) begin
      inputCountFaultPin <= 4'(1 << n);
      settle();
      expect_word(OFS_INPUT_CNT, 16'(1 << n));
      expect_word(OFS_DEVICE, 16'h0400);
    end
    inputCountFaultPin <= 4'h0;
    registeredUnits <= 8'hFF;
    silentUnits     <= 8'h05;
    repeat (40) @(posedge clk);
    expect_word(OFS_CFG_A, 16'h0010);
    silentUnits <= 8'h00;
    settle();
    expect_word(OFS_CFG_A, 16'h0000);
    registeredUnits <= 8'h00;
    attachUnknown <= 1'b1; faultUnits <= 8'hFF; inputCountFaultPin <= 4'hF;
    settle();
    for (n = 0; n < 6; n++) wr(16'h0000 + 16'(n), 16'hFFFF);
    expect_word(OFS_DEVICE, 16'h0412);
    expect_word(OFS_CFG_A, 16'h0009);
    expect_word(OFS_CFG_B, 16'h00FF);
    expect_word(OFS_LINK_UNIT, 16'h00FF);
    expect_word(OFS_INPUT_CNT, 16'h000F);
    attachUnknown <= 1'b0; faultUnits <= 8'h00; inputCountFaultPin <= 4'h0;
    settle();
    wr(OFS_INT_STATUS, 16'hFFFF);
    expect_word(OFS_INT_STATUS, 16'h0000);
    attachUnknown <= 1'b1;
    settle();
    #1;
    `CHK(irq, 1'b0)
    expect_word(OFS_INT_STATUS, 16'h0002);
    wr(OFS_INT_MASK, 16'h0412);
    expect_word(OFS_INT_MASK, 16'h0412);
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(irq, 1'b1)
    attachUnknown <= 1'b0;
    settle();
    wr(OFS_INT_STATUS, 16'h0002);
    settle();
    #1;
    `CHK(irq, 1'b0)
    expect_word(OFS_INT_STATUS, 16'h0000);
    tally_and_finish();
  end

  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_expansion_config_error_status

// [inc/fault_status_pkg.sv]
// Constants for the expansion fault status register bank
package fault_status_pkg;

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam logic [15:0] OFS_DEVICE      = 16'h0000;
  localparam logic [15:0] OFS_CFG_A       = 16'h0002;
  localparam logic [15:0] OFS_CFG_B       = 16'h0003;
  localparam logic [15:0] OFS_LINK_UNIT   = 16'h0004;
  localparam logic [15:0] OFS_INPUT_CNT   = 16'h0005;
  localparam logic [15:0] OFS_INT_STATUS  = 16'h0010;
  localparam logic [15:0] OFS_INT_MASK    = 16'h0011;
  localparam logic [15:0] RESET_WORD      = 16'h0000;
  localparam logic [15:0] UNMAPPED_WORD   = 16'h0000;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG_A_UNKNOWN   = 0;
  localparam int CFG_A_TOO_MANY  = 2;
  localparam int CFG_A_COMM      = 3;
  localparam int CFG_A_LOST      = 4;
  localparam int DEV_CFG_FAULT   = 1;
  localparam int DEV_LINK_FAULT  = 4;
  localparam int DEV_INPUT_FAULT = 10;

  // Masks of used bits; everything else reads zero
  localparam logic [15:0] CFG_A_USED   = 16'h001D;
  localparam logic [15:0] UNIT_USED    = 16'h00FF;
  localparam logic [15:0] INPUT_USED   = 16'h000F;
  localparam logic [15:0] DEVICE_USED  = 16'h0412;

  // ------------------------------------------------------------
  // Expansion chain
  // ------------------------------------------------------------
  localparam int          NUM_UNITS    = 8;
  localparam int          NUM_INPUTS   = 4;
  localparam int          COUNT_W      = 4;
  localparam logic [3:0]  MAX_ATTACHED = 4'h9;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int RESP_TIMEOUT_NS = 100000;
  localparam int RESP_TIMEOUT_CYC =
    (RESP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : fault_status_pkg

// [rtl/expansion_config_error_status.sv]
// Expansion unit fault status register bank with summary and interrupt
// Functional notes
// - Word A bit 0 is high while an unrecognised unit is attached.
// - Word A bit 2 is high while more than nine units are attached.
// - Word A bit 3 is high while any unit has a communication fault.
// - Word A bit 4 is high when a registered unit stops answering.
// - Word B bits 0 to 7 flag faults of units 1 to 8.
// - Link word bits 0 to 7 flag faults of units 1 to 8.
// - Input word bits 0 to 3 flag count errors of inputs 1 to 4.
// - Device word bit 1 tracks configuration faults, bit 4 link faults.
// - Device word bit 10 tracks any input count fault.
`timescale 1ns/1ps
module expansion_config_error_status
  import fault_status_pkg::*;
#(
  parameter int TIMEOUT_CYC = fault_status_pkg::RESP_TIMEOUT_CYC
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic [fault_status_pkg::ADDR_W-1:0]   addr,
  input  wire logic [fault_status_pkg::DATA_W-1:0]   wrData,
  input  wire logic                                  wrStb,
  input  wire logic                                  rdStb,
  output logic      [fault_status_pkg::DATA_W-1:0]   rdData,
  output logic                                       irq,
  input  wire logic                                  unknownUnitPin,
  input  wire logic [fault_status_pkg::COUNT_W-1:0]  unitCountPin,
  input  wire logic [fault_status_pkg::NUM_UNITS-1:0] unitCommFaultPin,
  input  wire logic [fault_status_pkg::NUM_UNITS-1:0] unitRegisteredPin,
  input  wire logic [fault_status_pkg::NUM_UNITS-1:0] unitResponsePin,
  input  wire logic [fault_status_pkg::NUM_INPUTS-1:0] inputCountFaultPin
);

  import fault_status_pkg::*;

  localparam int TMR_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(TIMEOUT_CYC - 1);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rstMeta_n;
  logic rstSync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  localparam int PIN_W = 1 + COUNT_W + 4 * NUM_UNITS + NUM_INPUTS - NUM_UNITS;

  logic [PIN_W-1:0]      pinSync;
  logic                  unknownS;
  logic [COUNT_W-1:0]    countS;
  logic [NUM_UNITS-1:0]  commS;
  logic [NUM_UNITS-1:0]  regS;
  logic [NUM_UNITS-1:0]  respS;
  logic [NUM_INPUTS-1:0] inputS;

  fault_sync #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .clk       (clk),
    .rstSync_n (rstSync_n),
    .asyncIn   ({unknownUnitPin, unitCountPin, unitCommFaultPin,
                 unitRegisteredPin, unitResponsePin, inputCountFaultPin}),
    .syncOut   (pinSync)
  );

  assign {unknownS, countS, commS, regS, respS, inputS} = pinSync;

  // ------------------------------------------------------------
  // Unit count qualification
  // ------------------------------------------------------------
  // Multi-bit count is only accepted once two samples agree
  logic [COUNT_W-1:0] countPrev;
  logic [COUNT_W-1:0] countStable;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      countPrev   <= '0;
      countStable <= '0;
    end else begin
      countPrev <= countS;
      if (countPrev == countS) begin
        countStable <= countS;
      end
    end
  end

  // ------------------------------------------------------------
  // Response watchdog per registered unit
  // ------------------------------------------------------------
  logic [NUM_UNITS-1:0] respPrev;
  logic [NUM_UNITS-1:0] respEdge;
  logic [TMR_W-1:0]     respTimer [NUM_UNITS];
  logic [NUM_UNITS-1:0] lostUnit;

  assign respEdge = respS ^ respPrev;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      respPrev <= '0;
      lostUnit <= '0;
      for (int i = 0; i < NUM_UNITS; i++) begin
        respTimer[i] <= '0;
      end
    end else begin
      respPrev <= respS;
      for (int i = 0; i < NUM_UNITS; i++) begin
        if (!regS[i] || respEdge[i]) begin
          respTimer[i] <= '0;
          lostUnit[i]  <= 1'b0;
        end else if (respTimer[i] == TMR_LAST) begin
          lostUnit[i]  <= 1'b1;
        end else begin
          respTimer[i] <= respTimer[i] + TMR_W'(1);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Status words
  // ------------------------------------------------------------
  logic [DATA_W-1:0] cfgWordA;
  logic [DATA_W-1:0] cfgWordB;
  logic [DATA_W-1:0] linkWord;
  logic [DATA_W-1:0] inputWord;
  logic [DATA_W-1:0] deviceWord;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cfgWordA <= RESET_WORD;
    end else begin
      cfgWordA                 <= RESET_WORD;
      cfgWordA[CFG_A_UNKNOWN]  <= unknownS;
      cfgWordA[CFG_A_TOO_MANY] <= countStable > MAX_ATTACHED;
      cfgWordA[CFG_A_COMM]     <= |commS;
      cfgWordA[CFG_A_LOST]     <= |lostUnit;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cfgWordB  <= RESET_WORD;
      linkWord  <= RESET_WORD;
      inputWord <= RESET_WORD;
    end else begin
      cfgWordB  <= {{(DATA_W - NUM_UNITS){1'b0}}, commS};
      linkWord  <= {{(DATA_W - NUM_UNITS){1'b0}}, commS};
      inputWord <= {{(DATA_W - NUM_INPUTS){1'b0}}, inputS};
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      deviceWord <= RESET_WORD;
    end else begin
      deviceWord                  <= RESET_WORD;
      deviceWord[DEV_CFG_FAULT]   <= |{cfgWordA, cfgWordB};
      deviceWord[DEV_LINK_FAULT]  <= |linkWord;
      deviceWord[DEV_INPUT_FAULT] <= |inputWord;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  logic [DATA_W-1:0] devicePrev;
  logic [DATA_W-1:0] intStatus;
  logic [DATA_W-1:0] intMask;
  logic [DATA_W-1:0] intRise;
  logic [DATA_W-1:0] intClear;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign intRise  = deviceWord & ~devicePrev;
  assign intClear = (wrStb && hit(addr, OFS_INT_STATUS)) ? wrData : RESET_WORD;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      devicePrev <= RESET_WORD;
      intStatus  <= RESET_WORD;
    end else begin
      devicePrev <= deviceWord;
      // Set wins over a clear in the same cycle
      intStatus  <= ((intStatus & ~intClear) | intRise) & DEVICE_USED;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      intMask <= RESET_WORD;
    end else if (wrStb && hit(addr, OFS_INT_MASK)) begin
      intMask <= wrData & DEVICE_USED;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus & intMask);
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  logic [DATA_W-1:0] next_rdData;

  always_comb begin
    unique case (addr)
      OFS_DEVICE:     next_rdData = deviceWord & DEVICE_USED;
      OFS_CFG_A:      next_rdData = cfgWordA & CFG_A_USED;
      OFS_CFG_B:      next_rdData = cfgWordB & UNIT_USED;
      OFS_LINK_UNIT:  next_rdData = linkWord & UNIT_USED;
      OFS_INPUT_CNT:  next_rdData = inputWord & INPUT_USED;
      OFS_INT_STATUS: next_rdData = intStatus;
      OFS_INT_MASK:   next_rdData = intMask;
      default:        next_rdData = UNMAPPED_WORD;
    endcase
  end

  // Data stand for one cycle only after the read strobe
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rdData <= RESET_WORD;
    end else if (rdStb) begin
      rdData <= next_rdData;
    end else begin
      rdData <= RESET_WORD;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_unknown_flag: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    cfgWordA[CFG_A_UNKNOWN] == $past(unknownS))
    else $error("Unknown unit flag does not follow its input");

  a_too_many_units: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    cfgWordA[CFG_A_TOO_MANY] == ($past(countStable) > MAX_ATTACHED))
    else $error("Too many units flag wrong");

  a_comm_summary: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    cfgWordA[CFG_A_COMM] == (|cfgWordB))
    else $error("Communication summary disagrees with per-unit word");

  a_lost_timeout: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    (regS[0] && !respEdge[0] && respTimer[0] == TMR_LAST)
      |=> lostUnit[0] ##1 cfgWordA[CFG_A_LOST])
    else $error("Lost unit not flagged after timeout");

  a_unit_word_map: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    cfgWordB[NUM_UNITS-1:0] == $past(commS))
    else $error("Word B does not follow unit faults");

  a_link_word_same: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    linkWord[NUM_UNITS-1:0] == $past(commS) && linkWord[DATA_W-1:NUM_UNITS] == '0)
    else $error("Link word does not follow unit faults");

  a_input_word_map: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    $rose(inputS[0]) |=> inputWord[0] ##1 deviceWord[DEV_INPUT_FAULT])
    else $error("Input fault not reported");

  a_device_cfg_bit: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    deviceWord[DEV_CFG_FAULT] == $past(|{cfgWordA, cfgWordB}))
    else $error("Device configuration summary wrong");

  a_device_io_bit: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    deviceWord[DEV_INPUT_FAULT] == $past(|inputWord))
    else $error("Device input summary wrong");

  a_unused_zero: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    (cfgWordA & ~CFG_A_USED) == RESET_WORD && (inputWord & ~INPUT_USED) == RESET_WORD
      && (deviceWord & ~DEVICE_USED) == RESET_WORD)
    else $error("Unused status bit set");

  a_read_cfg_a: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    (rdStb && addr == OFS_CFG_A) |=> rdData == ($past(cfgWordA) & CFG_A_USED))
    else $error("Word A read returns wrong data");

  a_irq_level: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    irq == $past(|(intStatus & intMask)))
    else $error("Interrupt level wrong");

endmodule : expansion_config_error_status

// [rtl/fault_sync.sv]
// Two-stage synchroniser for a vector of level inputs
`timescale 1ns/1ps
module fault_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstSync_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : fault_sync
